// ===== verilog/pump_pkg.sv
// Constants for the charge pump level control block.
// Assumes an 8-bit register port and a 50 MHz core clock.
package pump_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PUMP_CONTROL_ADDR   = 8'hac;
  localparam logic [7:0] PUMP_TIMING_ADDR    = 8'had;
  localparam logic [7:0] HALF_RAIL_THR_ADDR  = 8'hae;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PUMP_ON_BIT         = 7;
  localparam int LIGHT_LOAD_BIT      = 6;
  localparam int TRACK_SEL_LSB       = 4;
  localparam int MANUAL_LEVEL_LSB    = 2;
  localparam int DECAY_LSB           = 3;
  localparam int CLK_DIV_LSB         = 0;
  localparam int THRESHOLD_LSB       = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       PUMP_ON_RST      = 1'h0;
  localparam logic       LIGHT_LOAD_RST   = 1'h1;
  localparam logic [1:0] TRACK_SEL_RST    = 2'h2;
  localparam logic [1:0] MANUAL_LEVEL_RST = 2'h0;
  localparam logic [2:0] DECAY_RST        = 3'h2;
  localparam logic [2:0] CLK_DIV_RST      = 3'h1;
  localparam logic [5:0] THRESHOLD_RST    = 6'h0e;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRACK_MANUAL  = 2'b00,
    TRACK_MAX_VOL = 2'b01,
    TRACK_DAC_VOL = 2'b10,
    TRACK_SIGNAL  = 2'b11
  } track_sel_t;
  typedef enum logic [1:0] {
    LEVEL_STANDBY  = 2'b00,
    LEVEL_RESERVED = 2'b01,
    LEVEL_HALF     = 2'b10,
    LEVEL_FULL     = 2'b11
  } rail_level_t;
  localparam logic [2:0] CLK_DIV_STOP = 3'h5;
  localparam logic [2:0] CLK_DIV_MAX  = 3'h4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_HZ     = 50_000_000;
  localparam int DECAY_UNIT_MS   = 1;
  localparam int CYCLES_PER_MS   = CORE_CLK_HZ / 1000 * DECAY_UNIT_MS;
  localparam logic [9:0] DECAY_MS_0 = 10'h000;
  localparam logic [9:0] DECAY_MS_1 = 10'h002;
  localparam logic [9:0] DECAY_MS_2 = 10'h004;
  localparam logic [9:0] DECAY_MS_3 = 10'h010;
  localparam logic [9:0] DECAY_MS_4 = 10'h040;
  localparam logic [9:0] DECAY_MS_5 = 10'h080;
  localparam logic [9:0] DECAY_MS_7 = 10'h200;
endpackage

// ===== verilog/pump_clk_if.sv
// Carrier between the level controller and the pump clock divider.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pump_clk_if;
  logic [2:0] divide_code;
  logic       run;
  logic       pump_clk;
  logic       stopped;
  modport ctrl (output divide_code, output run, input pump_clk,
                input stopped);
  modport div  (input divide_code, input run, output pump_clk,
                output stopped);
endinterface

// ===== verilog/pump_clk_divider.sv
// Divides the core clock down to the pump switching clock.
// Assumes a legal divide code; reserved codes stop the clock.
`timescale 1ns/1ps
module pump_clk_divider (
  input  wire logic core_clk,  // core clock
  input  wire logic rst,       // async reset, high
  pump_clk_if.div   ctl        // divide code in, pump clock out
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       clk;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [6:0] half_m1;

  // ----------------------------------------------------------------
  // Half period from code: 4 << code cycles
  // ----------------------------------------------------------------
  always_comb
  begin
    half_m1 = 7'((7'h04 << ctl.divide_code) - 7'h01);
    s_d     = s_q;
    if (!ctl.run || ctl.divide_code > pump_pkg::CLK_DIV_MAX)
    begin
      s_d.cnt = 7'h00;
      s_d.clk = 1'b0;
    end
    else if (s_q.cnt >= half_m1)
    begin
      s_d.cnt = 7'h00;
      s_d.clk = ~s_q.clk;
    end
    else
    begin
      s_d.cnt = 7'(s_q.cnt + 7'h01);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ctl.pump_clk = s_q.clk;
  assign ctl.stopped  = (ctl.divide_code > pump_pkg::CLK_DIV_MAX);
endmodule // pump_clk_divider

// ===== verilog/pump_level_ctrl.sv
// Charge pump level control: registers, level tracking, decay, clock.
// Assumes a synchronous register port and volume inputs on core_clk.
// Function
// - Pump runs only while control bit 7 is set; resets off.
// - Control bit 6 selects light-load low-power mode; resets on.
// - Bits 5:4 select level source: manual, max volume, DAC, signal.
// - Manual level bits 3:2: standby, reserved, half, full; resets 0.
// - Timing bits 5:3 set full-to-half decay time, 0 to 512 ms.
// - Timing bits 2:0 divide core clock 8..128; code 5 stops it.
// - Half rail allowed when tracked level at or below threshold.
// - Threshold applies only in DAC volume or signal tracking.
`timescale 1ns/1ps
module pump_level_ctrl #(
  parameter int MS_CYCLES = pump_pkg::CYCLES_PER_MS  // cycles per ms
) (
  input  wire logic       core_clk,         // 50 MHz core clock
  input  wire logic       rst,              // async reset, high
  input  wire logic [7:0] reg_addr,         // register address
  input  wire logic       reg_wr,           // write strobe
  input  wire logic [7:0] reg_wdata,        // write data
  input  wire logic       reg_rd,           // read strobe
  output logic      [7:0] reg_rdata,        // read data, registered
  output logic            reg_rvalid,       // read data valid pulse
  input  wire logic [5:0] max_out_volume,   // largest output volume
  input  wire logic [5:0] dac_volume,       // playback converter volume
  input  wire logic [5:0] signal_magnitude, // signal magnitude
  output logic            pump_on,          // pump running
  output logic            light_load_saver, // low-power light-load mode
  output logic      [1:0] rail_level,       // 00 off, 10 half, 11 full
  output logic            pump_clock,       // pump switching clock
  output logic            pump_clock_stopped // analog feedback only
);
  typedef struct packed {
    logic       pump_on;
    logic       light_load;
    logic [1:0] track_sel;
    logic [1:0] manual_level;
    logic [2:0] decay;
    logic [2:0] clk_div;
    logic [5:0] threshold;
    logic [1:0] level;
    logic [9:0] decay_ms;
    logic [31:0] ms_cnt;
    logic [7:0] rdata;
    logic       rvalid;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  pump_clk_if  clk_bus ();

  logic [5:0] tracked;
  logic [1:0] target;
  logic [9:0] decay_limit;

  // ----------------------------------------------------------------
  // Decay time lookup
  // ----------------------------------------------------------------
  function automatic logic [9:0] decay_time(input logic [2:0] code);
    unique case (code)
      3'h0:    decay_time = pump_pkg::DECAY_MS_0;
      3'h1:    decay_time = pump_pkg::DECAY_MS_1;
      3'h2:    decay_time = pump_pkg::DECAY_MS_2;
      3'h3:    decay_time = pump_pkg::DECAY_MS_3;
      3'h4:    decay_time = pump_pkg::DECAY_MS_4;
      3'h5:    decay_time = pump_pkg::DECAY_MS_5;
      // Code 6 has no defined time; longest one used
      default: decay_time = pump_pkg::DECAY_MS_7;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d         = s_q;
    s_d.rvalid  = 1'b0;
    decay_limit = decay_time(s_q.decay);
    tracked     = 6'h00;
    target      = pump_pkg::LEVEL_FULL;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        pump_pkg::PUMP_CONTROL_ADDR:
        begin
          s_d.pump_on      = reg_wdata[pump_pkg::PUMP_ON_BIT];
          s_d.light_load   = reg_wdata[pump_pkg::LIGHT_LOAD_BIT];
          s_d.track_sel    = reg_wdata[pump_pkg::TRACK_SEL_LSB +: 2];
          s_d.manual_level = reg_wdata[pump_pkg::MANUAL_LEVEL_LSB +: 2];
        end
        pump_pkg::PUMP_TIMING_ADDR:
        begin
          s_d.decay   = reg_wdata[pump_pkg::DECAY_LSB +: 3];
          s_d.clk_div = reg_wdata[pump_pkg::CLK_DIV_LSB +: 3];
        end
        pump_pkg::HALF_RAIL_THR_ADDR:
          s_d.threshold = reg_wdata[pump_pkg::THRESHOLD_LSB +: 6];
        default: ;
      endcase
    end

    // Register reads, reserved bits zero
    if (reg_rd)
    begin
      s_d.rvalid = 1'b1;
      unique case (reg_addr)
        pump_pkg::PUMP_CONTROL_ADDR:
          s_d.rdata = {s_q.pump_on, s_q.light_load, s_q.track_sel,
                       s_q.manual_level, 2'b00};
        pump_pkg::PUMP_TIMING_ADDR:
          s_d.rdata = {2'b00, s_q.decay, s_q.clk_div};
        pump_pkg::HALF_RAIL_THR_ADDR:
          s_d.rdata = {2'b00, s_q.threshold};
        default:
          s_d.rdata = 8'h00;
      endcase
    end

    // Level source selection
    unique case (pump_pkg::track_sel_t'(s_q.track_sel))
      pump_pkg::TRACK_MANUAL:
        target = s_q.manual_level;
      pump_pkg::TRACK_MAX_VOL:
      begin
        tracked = max_out_volume;
        target  = pump_pkg::LEVEL_FULL;
      end
      pump_pkg::TRACK_DAC_VOL:
      begin
        tracked = dac_volume;
        target  = (tracked <= s_q.threshold) ? pump_pkg::LEVEL_HALF
                                             : pump_pkg::LEVEL_FULL;
      end
      pump_pkg::TRACK_SIGNAL:
      begin
        tracked = signal_magnitude;
        target  = (tracked <= s_q.threshold) ? pump_pkg::LEVEL_HALF
                                             : pump_pkg::LEVEL_FULL;
      end
    endcase

    // Rail level with full-to-half decay
    // Rising to full is immediate so the load never sags
    if (!s_q.pump_on)
    begin
      s_d.level    = pump_pkg::LEVEL_STANDBY;
      s_d.decay_ms = 10'h000;
      s_d.ms_cnt   = 32'h0000_0000;
    end
    else if (s_q.level == pump_pkg::LEVEL_FULL &&
             target == pump_pkg::LEVEL_HALF)
    begin
      if (s_q.decay_ms >= decay_limit)
      begin
        s_d.level    = pump_pkg::LEVEL_HALF;
        s_d.decay_ms = 10'h000;
        s_d.ms_cnt   = 32'h0000_0000;
      end
      else if (s_q.ms_cnt >= 32'(MS_CYCLES - 1))
      begin
        s_d.ms_cnt   = 32'h0000_0000;
        s_d.decay_ms = 10'(s_q.decay_ms + 10'h001);
      end
      else
        s_d.ms_cnt = 32'(s_q.ms_cnt + 32'h0000_0001);
    end
    else
    begin
      s_d.level    = target;
      s_d.decay_ms = 10'h000;
      s_d.ms_cnt   = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q              <= '0;
      s_q.pump_on      <= pump_pkg::PUMP_ON_RST;
      s_q.light_load   <= pump_pkg::LIGHT_LOAD_RST;
      s_q.track_sel    <= pump_pkg::TRACK_SEL_RST;
      s_q.manual_level <= pump_pkg::MANUAL_LEVEL_RST;
      s_q.decay        <= pump_pkg::DECAY_RST;
      s_q.clk_div      <= pump_pkg::CLK_DIV_RST;
      s_q.threshold    <= pump_pkg::THRESHOLD_RST;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Pump clock
  // ----------------------------------------------------------------
  assign clk_bus.divide_code = s_q.clk_div;
  assign clk_bus.run         = s_q.pump_on;

  pump_clk_divider u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .ctl      (clk_bus.div)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata          = s_q.rdata;
  assign reg_rvalid         = s_q.rvalid;
  assign pump_on            = s_q.pump_on;
  // Saver mode only shown while the pump runs
  assign light_load_saver   = s_q.pump_on & s_q.light_load;
  assign rail_level         = s_q.level;
  assign pump_clock         = clk_bus.pump_clk;
  assign pump_clock_stopped = clk_bus.stopped;
endmodule // pump_level_ctrl

// ===== testbench/pump_level_props.sv
// Assertions on the charge pump level control ports.
// Assumes binding into pump_level_ctrl at its port boundary.
`timescale 1ns/1ps
module pump_level_props #(
  parameter int MS_CYCLES = 4  // cycles per ms
) (
  input wire logic       core_clk,          // core clock
  input wire logic       rst,               // async reset
  input wire logic [7:0] reg_addr,          // address
  input wire logic       reg_wr,            // write strobe
  input wire logic [7:0] reg_wdata,         // write data
  input wire logic       reg_rd,            // read strobe
  input wire logic [7:0] reg_rdata,         // read data
  input wire logic       reg_rvalid,        // read valid
  input wire logic       pump_on,           // pump running
  input wire logic       light_load_saver,  // light-load mode
  input wire logic [1:0] rail_level,        // rail level
  input wire logic       pump_clock,        // pump clock
  input wire logic       pump_clock_stopped // clock stopped
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wr_ctl;
  logic wr_tim;
  logic mapped;
  assign wr_ctl = reg_wr && reg_addr == pump_pkg::PUMP_CONTROL_ADDR;
  assign wr_tim = reg_wr && reg_addr == pump_pkg::PUMP_TIMING_ADDR;
  assign mapped = reg_addr inside {8'hac, 8'had, 8'hae};
  a_pump_on_write: assert property (
    wr_ctl |=> pump_on == $past(reg_wdata[7])) else $error("pump_on bad");
  a_pump_on_hold: assert property (
    !wr_ctl |=> $stable(pump_on)) else $error("pump_on moved");
  a_off_clock_low: assert property (
    !pump_on [*4] |-> !pump_clock) else $error("clock while off");
  a_saver_gated: assert property (
    wr_ctl |=> light_load_saver ==
      ($past(reg_wdata[7]) && $past(reg_wdata[6])))
    else $error("saver mode wrong after write");
  a_saver_set: assert property (
    wr_ctl && reg_wdata[7:6] == 2'h3 |=> ##[0:1] light_load_saver)
    else $error("saver not set");
  a_stop_code: assert property (
    wr_tim |=> pump_clock_stopped == ($past(reg_wdata[2:0]) > 3'h4))
    else $error("stop flag wrong");
  a_stopped_low: assert property (
    pump_clock_stopped [*4] |-> !pump_clock) else $error("clock runs");
  a_unmapped_zero: assert property (
    reg_rd && !mapped |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_ctl_reserved: assert property (
    reg_rd && reg_addr == 8'hac |=> reg_rdata[1:0] == 2'h0)
    else $error("control spare bits set");
  a_top_reserved: assert property (
    reg_rd && reg_addr inside {8'had, 8'hae} |=> reg_rdata[7:6] == 2'h0)
    else $error("upper spare bits set");
  c_half_rail: cover property (rail_level == 2'h2);
  c_stopped: cover property (pump_clock_stopped);
  c_clock_rise: cover property (pump_on && $rose(pump_clock));
endmodule // pump_level_props

bind pump_level_ctrl pump_level_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .pump_on(pump_on),
  .light_load_saver(light_load_saver), .rail_level(rail_level),
  .pump_clock(pump_clock), .pump_clock_stopped(pump_clock_stopped));

// ===== testbench/tb_charge_pump_level_control.sv
// Self-checking bench for the charge pump level control block.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps
module tb_charge_pump_level_control;
  localparam int MS = 4;
  typedef struct {
    logic [7:0] ctl;
    logic [5:0] thr, dac, sig;
    logic [1:0] lvl;
  } row_t;
  logic       core_clk, rst, reg_wr, reg_rd, reg_rvalid, pump_on;
  logic       light_load_saver, pump_clock, pump_clock_stopped;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [5:0] max_out_volume, dac_volume, signal_magnitude;
  logic [1:0] rail_level, rv_seen;
  int         n_errors, total_checks, cnt;
  logic [2:0] dcode [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  int         dms [6]   = '{2, 4, 16, 64, 128, 512};
  logic [7:0] rbk [4]   = '{8'hfc, 8'h3f, 8'h3f, 8'h00};
  row_t       rows [10] = '{
    '{8'ha0, 6'h0e, 6'h0e, 6'h3f, 2'h2}, '{8'ha0, 6'h0e, 6'h0f, 6'h00, 2'h3},
    '{8'ha0, 6'h00, 6'h00, 6'h3f, 2'h2}, '{8'ha0, 6'h00, 6'h01, 6'h00, 2'h3},
    '{8'hb0, 6'h0e, 6'h3f, 6'h0e, 2'h2}, '{8'hb0, 6'h0e, 6'h00, 6'h0f, 2'h3},
    '{8'h90, 6'h3f, 6'h00, 6'h00, 2'h3}, '{8'h80, 6'h3f, 6'h00, 6'h00, 2'h0},
    '{8'h8c, 6'h00, 6'h3f, 6'h3f, 2'h3}, '{8'h88, 6'h3f, 6'h00, 6'h00, 2'h2}};

  pump_level_ctrl #(.MS_CYCLES(MS)) uut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .max_out_volume(max_out_volume),
    .dac_volume(dac_volume), .signal_magnitude(signal_magnitude),
    .pump_on(pump_on), .light_load_saver(light_load_saver),
    .rail_level(rail_level), .pump_clock(pump_clock),
    .pump_clock_stopped(pump_clock_stopped));

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    rv_seen[1] = reg_rvalid;
    reg_rd = 1'h0;
    @(negedge core_clk);
    rv_seen[0] = reg_rvalid;
    d = reg_rdata;
  endtask
  // Length of the first full high phase in a 600-cycle window
  task automatic high_time(output int p);
    int k;
    p = 0;
    k = 0;
    repeat (600)
    begin
      @(negedge core_clk);
      if (k == 0 && pump_clock === 1'h0) k = 1;
      else if (k == 1 && pump_clock === 1'h1) k = 2;
      if (k == 2 && pump_clock === 1'h1) p++;
      else if (k == 2) k = 3;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
    {max_out_volume, dac_volume, signal_magnitude} = 18'h0_0000;
    rst = 1'h1;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'h0;
    rd(8'hac, rd_val);
    check(rd_val, 8'h60);
    rd(8'had, rd_val);
    check(rd_val, 8'h11);
    rd(8'hae, rd_val);
    check(rd_val, 8'h0e);
    check({6'h0, pump_on, light_load_saver}, 8'h00);
    check({5'h0, rail_level, pump_clock_stopped}, 8'h00);
    $display("test reset done");
    wr(8'had, 8'h01);
    foreach (rows[i])
    begin
      wr(8'hac, rows[i].ctl);
      wr(8'hae, {2'h0, rows[i].thr});
      dac_volume = rows[i].dac;
      signal_magnitude = rows[i].sig;
      repeat (4) @(negedge core_clk);
      check({6'h0, rail_level}, {6'h0, rows[i].lvl});
    end
    $display("test level rows done");
    wr(8'hae, 8'h0e);
    wr(8'hac, 8'ha0);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'had, {2'h0, dcode[i], 3'h1});
      dac_volume = 6'h3f;
      repeat (4) @(negedge core_clk);
      dac_volume = 6'h05;
      repeat (dms[i] * MS) @(negedge core_clk);
      check({6'h0, rail_level}, 8'h03);
      @(negedge core_clk);
      check({6'h0, rail_level}, 8'h02);
    end
    $display("test decay done");
    wr(8'hac, 8'hc0);
    repeat (2) @(negedge core_clk);
    check({6'h0, pump_on, light_load_saver}, 8'h03);
    for (int c = 0; c < 7; c++)
    begin
      wr(8'had, 8'(c));
      high_time(cnt);
      check(8'(cnt), c < 5 ? 8'(4 << c) : 8'h00);
      check({7'h0, pump_clock_stopped}, {7'h0, c > 4});
    end
    wr(8'hac, 8'h40);
    wr(8'had, 8'h00);
    high_time(cnt);
    check({6'h0, pump_on, light_load_saver}, 8'h00);
    check(8'(cnt), 8'h00);
    $display("test pump clock done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hac + 8'(i), 8'hff);
      rd(8'hac + 8'(i), rd_val);
      check(rd_val, rbk[i]);
      check({6'h0, rv_seen}, 8'h02);
    end
    $display("test readback done");
    rst = 1'h1;
    @(negedge core_clk);
    rst = 1'h0;
    rd(8'hac, rd_val);
    check(rd_val, 8'h60);
    check({6'h0, pump_on, pump_clock}, 8'h00);
    $display("test mid reset done");
    give_verdict;
  end
endmodule // tb_charge_pump_level_control
